/* File: include/udc4_map.svh */
`ifndef UDC4_MAP_SVH
`define UDC4_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UDC4_OFS_CTRL 4'h0
`define UDC4_OFS_STATUS 4'h4
`define UDC4_OFS_SWPRE 4'h8
`define UDC4_OFS_CMD 4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UDC4_CTRL_INHIBIT 0
`define UDC4_CMD_LOAD 0
`define UDC4_ST_COUNT_LSB 0
`define UDC4_ST_LIMIT 4
`define UDC4_ST_CARRY_N 5
`define UDC4_ST_DIR 6
`define UDC4_ST_CE_N 7
`define UDC4_ST_LOAD_N 8

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define UDC4_CTRL_RST 1'h0
`define UDC4_SWPRE_RST 4'h0
`define UDC4_COUNT_MAX 4'hF
`define UDC4_COUNT_MIN 4'h0
`define UDC4_COUNT_STEP 4'h1
`define UDC4_SYNC_STAGES 2

`endif

/* File: include/udc4_pkg.sv */
package udc4_pkg;

  typedef logic [3:0] udc4_count_t;

  // Pin group sampled from outside the core clock domain
  typedef struct packed {
    logic load_n;
    logic ce_n;
    logic dir_down;
    logic cnt_clk;
    udc4_count_t preset;
  } udc4_pins_s;

  // Observable counter state
  typedef struct packed {
    logic load_n;
    logic ce_n;
    logic dir_down;
    logic carry_n;
    logic limit;
    udc4_count_t count;
  } udc4_status_s;

endpackage : udc4_pkg

/* File: verilog/udc4_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module udc4_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ----------------------------------------
  // Two flops per bit
  // ----------------------------------------
  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule : udc4_sync

`default_nettype wire

/* File: verilog/udc4_counter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "udc4_map.svh"

// Functional notes
// - Four-bit count wraps modulo sixteen in both directions.
// - Load low copies preset into count, overriding clock, enable, direction.
// - With load high and enable low, count changes only on clock rise or a software load.
// - Direction low increments, high decrements, sampled at counting edge.
// - Limit flag high at zero counting down or fifteen counting up.
// - Limit flag is a pure decode of count and direction.
// - Limit flag ignores count enable.
// - Carry pulse low during clock low phase when enabled and at limit.
// - Carry pulse returns high right after clock rises.
// - Carry pulse forced high when disabled or not at limit.
module udc4_counter
  import udc4_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic COUNT_CLOCK,
  input wire logic ASYNC_LOAD_N,
  input wire logic COUNT_ENABLE_N,
  input wire logic DIRECTION_DOWN,
  input wire logic [3:0] PRESET_VALUE,
  output logic [3:0] COUNT_VALUE,
  output logic LIMIT_FLAG,
  output logic CARRY_PULSE_N
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  udc4_pins_s pins_raw;
  udc4_pins_s pins_s;

  assign pins_raw.load_n = ASYNC_LOAD_N;
  assign pins_raw.ce_n = COUNT_ENABLE_N;
  assign pins_raw.dir_down = DIRECTION_DOWN;
  assign pins_raw.cnt_clk = COUNT_CLOCK;
  assign pins_raw.preset = PRESET_VALUE;

  udc4_sync #(
    .W($bits(udc4_pins_s))
  ) u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic inhibit_q;
  logic inhibit_d;
  udc4_count_t swpre_q;
  udc4_count_t swpre_d;
  logic swload_q;
  logic swload_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // ----------------------------------------
  // Counter state
  // ----------------------------------------
  udc4_count_t count_q;
  udc4_count_t count_d;
  logic clk_prev_q;
  logic clk_prev_d;
  logic limit_q;
  logic limit_d;
  logic carry_n_q;
  logic carry_n_d;
  logic clk_rise;
  logic enabled_n;
  udc4_status_s status;

  // Software inhibit only ever adds hold, never forces a count
  assign enabled_n = pins_s.ce_n | inhibit_q;
  assign clk_rise = pins_s.cnt_clk & ~clk_prev_q;

  always_comb begin
    count_d = count_q;
    clk_prev_d = pins_s.cnt_clk;
    if (!pins_s.load_n) begin
      count_d = pins_s.preset;
    end else if (swload_q) begin
      count_d = swpre_q;
    end else if (clk_rise && !enabled_n) begin
      if (pins_s.dir_down) begin
        count_d = count_q - `UDC4_COUNT_STEP;
      end else begin
        count_d = count_q + `UDC4_COUNT_STEP;
      end
    end
    // Decode of next count keeps flag aligned with count outputs
    limit_d = pins_s.dir_down ? (count_d == `UDC4_COUNT_MIN)
                              : (count_d == `UDC4_COUNT_MAX);
    // Low only in clock low phase, released as soon as clock rises
    carry_n_d = ~(~enabled_n & limit_d & ~pins_s.cnt_clk);
  end

  // No reset on the count itself: power-up value stays unknown
  always_ff @(posedge CORE_CLK) begin
    count_q <= count_d;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      clk_prev_q <= 1'b1;
      limit_q <= 1'b0;
      carry_n_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_prev_d;
      limit_q <= limit_d;
      carry_n_q <= carry_n_d;
    end
  end

  assign COUNT_VALUE = count_q;
  assign LIMIT_FLAG = limit_q;
  assign CARRY_PULSE_N = carry_n_q;

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  assign status.load_n = pins_s.load_n;
  assign status.ce_n = pins_s.ce_n;
  assign status.dir_down = pins_s.dir_down;
  assign status.carry_n = carry_n_q;
  assign status.limit = limit_q;
  assign status.count = count_q;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  logic req;
  logic wr;

  // Single wait state; unmapped reads return zero and still ack
  assign req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr = req & WB_WE_I & WB_SEL_I[0];

  always_comb begin
    ack_d = req;
    inhibit_d = inhibit_q;
    swpre_d = swpre_q;
    swload_d = 1'b0;
    rdata_d = rdata_q;
    if (wr) begin
      unique case (WB_ADR_I)
        `UDC4_OFS_CTRL: inhibit_d = WB_DAT_I[`UDC4_CTRL_INHIBIT];
        `UDC4_OFS_SWPRE: swpre_d = WB_DAT_I[3:0];
        `UDC4_OFS_CMD: swload_d = WB_DAT_I[`UDC4_CMD_LOAD];
        default: ;
      endcase
    end
    if (req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        `UDC4_OFS_CTRL: rdata_d = {31'h0000_0000, inhibit_q};
        `UDC4_OFS_STATUS: rdata_d = {23'h00_0000, status};
        `UDC4_OFS_SWPRE: rdata_d = {28'h000_0000, swpre_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
      inhibit_q <= `UDC4_CTRL_RST;
      swpre_q <= `UDC4_SWPRE_RST;
      swload_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      inhibit_q <= inhibit_d;
      swpre_q <= swpre_d;
      swload_q <= swload_d;
      rdata_q <= rdata_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;

endmodule : udc4_counter

`default_nettype wire

/* File: sim/udc4_counter_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module udc4_checker (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic COUNT_CLOCK,
  input wire logic ASYNC_LOAD_N,
  input wire logic COUNT_ENABLE_N,
  input wire logic DIRECTION_DOWN,
  input wire logic [3:0] PRESET_VALUE,
  input wire logic [3:0] COUNT_VALUE,
  input wire logic LIMIT_FLAG,
  input wire logic CARRY_PULSE_N
);
  // Count has no reset, so checks wait for a settled pin load
  logic [2:0] ld_q;
  logic [2:0] ld_d;
  always_comb ld_d = (!ASYNC_LOAD_N && ld_q < 3'h5) ? ld_q + 3'h1 : ld_q;
  always_ff @(posedge CORE_CLK) ld_q <= RST ? 3'h0 : ld_d;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST || ld_q != 3'h5);
  sequence s_run; (ASYNC_LOAD_N && $stable(DIRECTION_DOWN))[*5]; endsequence
  sequence s_dir; $stable(DIRECTION_DOWN)[*5]; endsequence
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  property p_lim; s_dir |-> LIMIT_FLAG == (DIRECTION_DOWN ? COUNT_VALUE == 4'h0 :
    COUNT_VALUE == 4'hF); endproperty
  property p_hold; (COUNT_ENABLE_N && ASYNC_LOAD_N)[*5] |=> $stable(COUNT_VALUE); endproperty
  property p_load; (!ASYNC_LOAD_N && $stable(PRESET_VALUE))[*5] |->
    COUNT_VALUE == PRESET_VALUE; endproperty
  property p_step; s_run ##0 $changed(COUNT_VALUE) |->
    COUNT_VALUE == $past(COUNT_VALUE) + (DIRECTION_DOWN ? 4'hF : 4'h1); endproperty
  property p_rc_ce; COUNT_ENABLE_N[*5] |-> CARRY_PULSE_N; endproperty
  property p_rc_hi; COUNT_CLOCK[*5] |-> CARRY_PULSE_N; endproperty
  property p_rc_lo; (!COUNT_CLOCK && !COUNT_ENABLE_N && ASYNC_LOAD_N && LIMIT_FLAG)[*5] |->
    !CARRY_PULSE_N; endproperty
  a_ack: assert property (p_ack) else $error("no bus ack");
  a_lim: assert property (p_lim) else $error("limit decode");
  a_hold: assert property (p_hold) else $error("count moved");
  a_load: assert property (p_load) else $error("preset lost");
  a_step: assert property (p_step) else $error("bad step");
  a_rc_ce: assert property (p_rc_ce) else $error("carry not held");
  a_rc_hi: assert property (p_rc_hi) else $error("carry in high phase");
  a_rc_lo: assert property (p_rc_lo) else $error("carry missing");
endmodule : udc4_checker
bind udc4_counter udc4_checker udc4_checker_i (.CORE_CLK, .RST, .WB_CYC_I, .WB_STB_I,
  .WB_ACK_O, .COUNT_CLOCK, .ASYNC_LOAD_N, .COUNT_ENABLE_N, .DIRECTION_DOWN, .PRESET_VALUE,
  .COUNT_VALUE, .LIMIT_FLAG, .CARRY_PULSE_N);
`default_nettype wire

/* File: sim/udc4_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none
module udc4_pins_model (
  input wire logic clk,
  output logic cnt_clk,
  output logic load_n,
  output logic ce_n,
  output logic dir_down,
  output logic [3:0] preset
);
  initial begin
    cnt_clk = 1'h0;
    load_n = 1'h1;
    ce_n = 1'h0;
    dir_down = 1'h0;
    preset = 4'h0;
  end
  // Clock from own phase count, never from the limit flag
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) cnt_clk <= 1'h1;
      repeat (5) @(posedge clk);
      cnt_clk <= 1'h0;
      repeat (6) @(posedge clk);
    end
  endtask : pulse
  task automatic load(input logic [3:0] v);
    @(posedge clk) preset <= v;
    load_n <= 1'h0;
    repeat (6) @(posedge clk);
    load_n <= 1'h1;
    repeat (4) @(posedge clk);
  endtask : load
  // Single stage: the global enable and the software inhibit make up its whole carry gate
  task automatic ctl(input logic c, input logic d);
    @(posedge clk) ce_n <= c;
    dir_down <= d;
    repeat (4) @(posedge clk);
  endtask : ctl
endmodule : udc4_pins_model
`default_nettype wire

/* File: sim/udc4_counter_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module udc4_counter_tb;
  logic clk, rst, cyc, stb, we, ack, cclk, ld_n, ce_n, dn, lim, rc_n;
  logic [3:0] adr, pre, cnt, sel;
  logic [31:0] dw, dr, rd;
  int error_cnt = 0;
  int n_tests = 0;
  udc4_pins_model udc4_pins_model_i (.clk(clk), .cnt_clk(cclk), .load_n(ld_n), .ce_n(ce_n),
    .dir_down(dn), .preset(pre));
  udc4_counter udc4_counter_i (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr),
    .WB_ACK_O(ack), .COUNT_CLOCK(cclk), .ASYNC_LOAD_N(ld_n), .COUNT_ENABLE_N(ce_n),
    .DIRECTION_DOWN(dn), .PRESET_VALUE(pre), .COUNT_VALUE(cnt), .LIMIT_FLAG(lim),
    .CARRY_PULSE_N(rc_n));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Wait for ack is bounded; a silent slave counts as a mismatch
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int t = 0;
    @(posedge clk) cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'h1 && t < 20);
    if (ack !== 1'h1) error_cnt++;
    rd = dr;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 4'h0;
    dw = 32'h0;
    sel = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    udc4_pins_model_i.load(4'hE);
    `CHK({cnt, lim}, 5'h1C)
    udc4_pins_model_i.pulse(1);
    `CHK({cnt, lim, rc_n}, 6'h3E)
    udc4_pins_model_i.pulse(1);
    `CHK({cnt, lim, rc_n}, 6'h01)
    udc4_pins_model_i.ctl(1'h0, 1'h1);
    `CHK({lim, rc_n}, 2'h2)
    udc4_pins_model_i.pulse(2);
    `CHK({cnt, lim}, 5'h1C)
    udc4_pins_model_i.ctl(1'h1, 1'h1);
    udc4_pins_model_i.pulse(1);
    `CHK(cnt, 4'hE)
    udc4_pins_model_i.load(4'hF);
    udc4_pins_model_i.ctl(1'h1, 1'h0);
    `CHK({lim, rc_n}, 2'h3)
    wb(1'h0, 4'h0, 32'h0, 4'h1);
    `CHK(rd, 32'h0000_0000)
    wb(1'h1, 4'h8, 32'h0000_0009, 4'h1);
    wb(1'h0, 4'h8, 32'h0, 4'h1);
    `CHK(rd, 32'h0000_0009)
    wb(1'h0, 4'hC, 32'h0, 4'h1);
    `CHK(rd, 32'h0000_0000)
    udc4_pins_model_i.ctl(1'h0, 1'h1);
    wb(1'h1, 4'h0, 32'h0000_0001, 4'h1);
    udc4_pins_model_i.pulse(1);
    `CHK(cnt, 4'hF)
    wb(1'h1, 4'h0, 32'h0, 4'h1);
    udc4_pins_model_i.pulse(1);
    wb(1'h0, 4'h4, 32'h0, 4'h1);
    `CHK(rd, 32'h0000_016E)
    // Lane 0 deselected must leave the preset alone
    wb(1'h1, 4'h8, 32'h0000_000D, 4'h1);
    wb(1'h1, 4'h8, 32'h0000_0003, 4'h0);
    wb(1'h1, 4'hC, 32'h0000_0001, 4'h1);
    wb(1'h0, 4'h4, 32'h0, 4'h1);
    `CHK(rd, 32'h0000_016D)
    `CHK(cnt, 4'hD)
    end_sim();
  end
endmodule : udc4_counter_tb
`default_nettype wire
